// File: core/oswd_top.sv
// Output safety watchdog: timeout counter, link-loss expiry, output forcing.
// Assumes an Avalon-MM master on one clock; normal channel values and link status
// come synchronous to sys_clk; unit_reset_req is looped to the chassis reset.
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "oswd_map.svh"
module oswd_top #(
    parameter int AO_W = 8,
    parameter int DO_W = 8,
    parameter int CO_W = 8
) (
    input  wire logic            sys_clk,
    input  wire logic            reset,
    input  wire logic [7:0]      avs_address,
    input  wire logic            avs_read,
    input  wire logic            avs_write,
    input  wire logic [31:0]     avs_writedata,
    input  wire logic [3:0]      avs_byteenable,
    output var  logic [31:0]     avs_readdata,
    output var  logic            avs_waitrequest,
    input  wire logic            link_up,
    input  wire logic [AO_W-1:0] ao_norm,
    input  wire logic [DO_W-1:0] do_norm,
    input  wire logic [CO_W-1:0] co_norm,
    output var  logic [AO_W-1:0] ao_out,
    output var  logic [DO_W-1:0] do_out,
    output var  logic [CO_W-1:0] co_out,
    output var  logic            wd_expired,
    output var  logic            app_notify,
    output var  logic            app_reset_req,
    output var  logic            unit_reset_req,
    output var  logic            ops_allowed
);
    import oswd_pkg::*;

    typedef struct packed {
        oswd_state_t          fsm;
        logic                 enable;
        logic                 link_exp;
        oswd_action_t         action;
        logic [31:0]          timeout;
        logic [31:0]          count;
        logic [AO_W-1:0]      ao_en;
        logic [DO_W-1:0]      do_en;
        logic [CO_W-1:0]      co_en;
        logic [AO_W-1:0]      ao_val;
        logic [DO_W-1:0]      do_val;
        logic [CO_W-1:0]      co_val;
        logic                 link_cause;
        logic                 app_flag;
        logic [2:0]           pulse_cnt;
        logic                 app_rst;
        logic                 unit_rst;
        logic                 ack;
        logic [31:0]          rdata;
        logic                 expired;
        logic                 ops_ok;
        logic                 wait_req;
    } oswd_top_t;
    oswd_top_t st, next_st;

    logic        acc;
    logic        wr_ok;
    logic [31:0] wmask;
    logic [31:0] wval;

    // One wait state per access, then the answer
    assign acc = (avs_read || avs_write) && !st.ack;
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // Writes blocked after expiry; reads stay open for diagnosis
    always_comb begin
        next_st = st;
        wr_ok = acc && avs_write && (st.fsm != OSWD_EXPIRED);
        wval = `OSWD_ZERO32;
        next_st.ack = acc;
        next_st.app_rst = 1'b0;
        next_st.unit_rst = 1'b0;
        if (wr_ok) begin
            case (avs_address)
                `OSWD_CTRL_ADDR: begin
                    // Config frozen while running so the period stays consistent
                    if (st.fsm == OSWD_IDLE && avs_byteenable[0]) begin
                        next_st.link_exp = avs_writedata[`OSWD_CTRL_LINKEXP];
                        next_st.action = oswd_action_t'(
                            avs_writedata[`OSWD_CTRL_ACT_HI:`OSWD_CTRL_ACT_LO]);
                        if (avs_writedata[`OSWD_CTRL_ENABLE]) begin
                            next_st.enable = 1'b1;
                            next_st.fsm = OSWD_RUN;
                            next_st.count = st.timeout;
                        end
                    end
                end
                `OSWD_TIMEOUT_ADDR: begin
                    if (st.fsm == OSWD_IDLE) begin
                        next_st.timeout = (st.timeout & ~wmask) | (avs_writedata & wmask);
                    end
                end
                `OSWD_CMD_ADDR: begin
                    if (st.fsm == OSWD_RUN && avs_writedata == `OSWD_CMD_REFRESH) begin
                        next_st.count = st.timeout;
                    end
                end
                `OSWD_AO_EN_ADDR:  next_st.ao_en  = avs_writedata[AO_W-1:0];
                `OSWD_DO_EN_ADDR:  next_st.do_en  = avs_writedata[DO_W-1:0];
                `OSWD_CO_EN_ADDR:  next_st.co_en  = avs_writedata[CO_W-1:0];
                `OSWD_AO_VAL_ADDR: next_st.ao_val = avs_writedata[AO_W-1:0];
                `OSWD_DO_VAL_ADDR: next_st.do_val = avs_writedata[DO_W-1:0];
                `OSWD_CO_VAL_ADDR: next_st.co_val = avs_writedata[CO_W-1:0];
                default: ;
            endcase
        end
        // Countdown and link watch; a refresh in the expiring cycle wins
        if (st.fsm == OSWD_RUN && !(wr_ok && avs_address == `OSWD_CMD_ADDR
                && avs_writedata == `OSWD_CMD_REFRESH)) begin
            if (st.link_exp && !link_up) begin
                next_st.fsm = OSWD_EXPIRED;
                next_st.link_cause = 1'b1;
            end else if (st.count == `OSWD_ZERO32) begin
                next_st.fsm = OSWD_EXPIRED;
            end else begin
                next_st.count = st.count - 32'h0000_0001;
            end
            if (next_st.fsm == OSWD_EXPIRED) begin
                next_st.app_flag = 1'b1;
                next_st.pulse_cnt = 3'(`OSWD_RST_PULSE);
            end
        end
        // Requested response, held a few cycles
        if (st.pulse_cnt != 3'h0) begin
            next_st.pulse_cnt = st.pulse_cnt - 3'h1;
            next_st.app_rst = (st.action == OSWD_ACT_APP_RST);
            next_st.unit_rst = (st.action == OSWD_ACT_UNIT_RST);
        end
        // Read mux
        case (avs_address)
            `OSWD_CTRL_ADDR: begin
                wval[`OSWD_CTRL_ENABLE] = st.enable;
                wval[`OSWD_CTRL_LINKEXP] = st.link_exp;
                wval[`OSWD_CTRL_ACT_HI:`OSWD_CTRL_ACT_LO] = st.action;
            end
            `OSWD_TIMEOUT_ADDR: wval = st.timeout;
            `OSWD_STATUS_ADDR: begin
                wval[`OSWD_ST_RUNNING] = (st.fsm == OSWD_RUN);
                wval[`OSWD_ST_EXPIRED] = (st.fsm == OSWD_EXPIRED);
                wval[`OSWD_ST_LINKCAUSE] = st.link_cause;
                wval[`OSWD_ST_APP_FLAG] = st.app_flag;
            end
            `OSWD_AO_EN_ADDR:  wval[AO_W-1:0] = st.ao_en;
            `OSWD_DO_EN_ADDR:  wval[DO_W-1:0] = st.do_en;
            `OSWD_CO_EN_ADDR:  wval[CO_W-1:0] = st.co_en;
            `OSWD_AO_VAL_ADDR: wval[AO_W-1:0] = st.ao_val;
            `OSWD_DO_VAL_ADDR: wval[DO_W-1:0] = st.do_val;
            `OSWD_CO_VAL_ADDR: wval[CO_W-1:0] = st.co_val;
            `OSWD_COUNT_ADDR:  wval = st.count;
            default: wval = `OSWD_ZERO32;
        endcase
        next_st.rdata = (acc && avs_read) ? wval : `OSWD_ZERO32;
        // Status pins registered from the next state, so no decode sits on a pin
        next_st.expired = (next_st.fsm == OSWD_EXPIRED);
        next_st.ops_ok = (next_st.fsm != OSWD_EXPIRED);
        next_st.wait_req = !acc;
    end

    // Only a unit reset disarms the watchdog
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st <= '0;
            st.timeout <= `OSWD_TIMEOUT_RST;
            st.wait_req <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata = st.rdata;
    assign avs_waitrequest = st.wait_req;
    assign wd_expired = st.expired;
    assign app_notify = st.app_flag;
    assign app_reset_req = st.app_rst;
    assign unit_reset_req = st.unit_rst;
    assign ops_allowed = st.ops_ok;

    // Channel forcing, one registered selector per class
    oswd_outmux #(.WIDTH(AO_W)) u_ao (.sys_clk(sys_clk), .reset(reset),
        .expired(wd_expired), .chan_en(st.ao_en), .exp_val(st.ao_val),
        .norm_val(ao_norm), .out_val(ao_out));
    oswd_outmux #(.WIDTH(DO_W)) u_do (.sys_clk(sys_clk), .reset(reset),
        .expired(wd_expired), .chan_en(st.do_en), .exp_val(st.do_val),
        .norm_val(do_norm), .out_val(do_out));
    oswd_outmux #(.WIDTH(CO_W)) u_co (.sys_clk(sys_clk), .reset(reset),
        .expired(wd_expired), .chan_en(st.co_en), .exp_val(st.co_val),
        .norm_val(co_norm), .out_val(co_out));

    a_count_expires: assert property (@(posedge sys_clk) disable iff (reset)
        st.fsm == OSWD_RUN && st.count == 32'h0 && !avs_write |=> wd_expired)
        else $error("counter reached zero without expiry");
    a_expiry_sticks: assert property (@(posedge sys_clk) disable iff (reset)
        wd_expired |=> wd_expired)
        else $error("expiry cleared without reset");
    a_forced_output: assert property (@(posedge sys_clk) disable iff (reset)
        wd_expired && $stable(st.ao_en) && $stable(st.ao_val) ##1 wd_expired
        |-> ao_out == (($past(st.ao_en) & $past(st.ao_val))
            | (~$past(st.ao_en) & $past(ao_norm))))
        else $error("analog outputs not forced");
    a_write_blocked: assert property (@(posedge sys_clk) disable iff (reset)
        wd_expired |=> $stable(st.timeout) && $stable(st.ao_en) && $stable(st.do_val))
        else $error("write took effect after expiry");
    a_count_steps: assert property (@(posedge sys_clk) disable iff (reset)
        st.fsm == OSWD_RUN && !avs_write && link_up && st.count != 32'h0
        |=> st.count == $past(st.count) - 32'h1)
        else $error("counter did not step by one tick");
    a_link_loss: assert property (@(posedge sys_clk) disable iff (reset)
        st.fsm == OSWD_RUN && st.link_exp && !link_up && !avs_write
        |=> wd_expired && st.link_cause)
        else $error("link loss did not expire");
    a_reset_default: assert property (@(posedge sys_clk)
        reset |=> ao_out == '0 && do_out == '0 && co_out == '0 && !wd_expired)
        else $error("outputs not at startup after reset");
    a_unit_response: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(wd_expired) && st.action == OSWD_ACT_UNIT_RST |=> unit_reset_req[*3])
        else $error("unit reset response missing");
    a_refresh_reload: assert property (@(posedge sys_clk) disable iff (reset)
        st.fsm == OSWD_RUN && avs_write && !st.ack && avs_address == `OSWD_CMD_ADDR
        && avs_writedata == `OSWD_CMD_REFRESH |=> st.count == st.timeout)
        else $error("refresh did not reload counter");
endmodule
`default_nettype wire

// File: core/oswd_map.svh
// Register map, field positions, reset values and timing figures of the output safety watchdog.
// Assumes inclusion by bare name from the package, oswd_top and the bench.
`ifndef OSWD_MAP_SVH
`define OSWD_MAP_SVH
// Word byte addresses on the register bus
`define OSWD_CTRL_ADDR      8'h00
`define OSWD_TIMEOUT_ADDR   8'h04
`define OSWD_CMD_ADDR       8'h08
`define OSWD_STATUS_ADDR    8'h0c
`define OSWD_AO_EN_ADDR     8'h10
`define OSWD_DO_EN_ADDR     8'h14
`define OSWD_CO_EN_ADDR     8'h18
`define OSWD_AO_VAL_ADDR    8'h1c
`define OSWD_DO_VAL_ADDR    8'h20
`define OSWD_CO_VAL_ADDR    8'h24
`define OSWD_COUNT_ADDR     8'h28
// Control field positions
`define OSWD_CTRL_ENABLE    0
`define OSWD_CTRL_LINKEXP   1
`define OSWD_CTRL_ACT_LO    2
`define OSWD_CTRL_ACT_HI    3
// Command codes written to the command word
`define OSWD_CMD_REFRESH    32'h0000_0001
// Status field positions
`define OSWD_ST_RUNNING     0
`define OSWD_ST_EXPIRED     1
`define OSWD_ST_LINKCAUSE   2
`define OSWD_ST_APP_FLAG    3
// Reset values
`define OSWD_TIMEOUT_RST    32'hffff_ffff
`define OSWD_ZERO32         32'h0000_0000
// Tick period in ns and clock period in ns; clock cycles per tick derived from them
`define OSWD_TICK_NS        25
`define OSWD_CLK_NS         25
`define OSWD_TICK_CYCLES    ((`OSWD_TICK_NS + `OSWD_CLK_NS - 1) / `OSWD_CLK_NS)
// Length of the unit reset and application reset pulses in clock cycles
`define OSWD_RST_PULSE      4
`endif

// File: core/oswd_pkg.sv
// Types shared by the output safety watchdog design files.
// Assumes the map header is on the include path.
`include "oswd_map.svh"
package oswd_pkg;
    // Watchdog states, Gray coded along idle -> run -> expired
    typedef enum logic [1:0] {
        OSWD_IDLE    = 2'b00,
        OSWD_RUN     = 2'b01,
        OSWD_EXPIRED = 2'b11
    } oswd_state_t;
    // Response chosen for an expiry
    typedef enum logic [1:0] {
        OSWD_ACT_NOTIFY   = 2'b00,
        OSWD_ACT_APP_RST  = 2'b01,
        OSWD_ACT_UNIT_RST = 2'b10,
        OSWD_ACT_RSVD     = 2'b11
    } oswd_action_t;
endpackage

// File: core/oswd_outmux.sv
// Per-channel output selector: normal value or expiration value, registered.
// Assumes the expiry level comes from a flip-flop in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module oswd_outmux #(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic             expired,
    input  wire logic [WIDTH-1:0] chan_en,
    input  wire logic [WIDTH-1:0] exp_val,
    input  wire logic [WIDTH-1:0] norm_val,
    output var  logic [WIDTH-1:0] out_val
);
    import oswd_pkg::*;
    typedef struct packed {
        logic [WIDTH-1:0] out;
    } oswd_mux_t;
    oswd_mux_t st, next_st;

    // Each channel picks its own source
    always_comb begin
        next_st = st;
        for (int i = 0; i < WIDTH; i++) begin
            next_st.out[i] = (expired && chan_en[i]) ? exp_val[i] : norm_val[i];
        end
    end

    // Reset brings outputs back to startup value
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign out_val = st.out;
endmodule
`default_nettype wire

// File: dv/oswd_host_model.sv
// Model of the host-side surroundings: network link state and normal channel values.
// Assumes the bench asks for a link drop; values stay fixed so outputs are predictable.
`timescale 1ns/1ps
`default_nettype none
module oswd_host_model #(
    parameter logic [7:0] AO_NORM = 8'h11,
    parameter logic [7:0] DO_NORM = 8'hc3,
    parameter logic [7:0] CO_NORM = 8'h5a
) (
    input  wire logic       drop_link,
    output var  logic       link_up,
    output var  logic [7:0] ao_norm,
    output var  logic [7:0] do_norm,
    output var  logic [7:0] co_norm
);
    // Link stays up unless a drop is ordered
    assign link_up = ~drop_link;
    // Static values: no other task runs while the watchdog starts, recovery only by reset
    assign ao_norm = AO_NORM;
    assign do_norm = DO_NORM;
    assign co_norm = CO_NORM;
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench of the output safety watchdog.
// Assumes a 40 MHz clock, Avalon-MM access with one wait state, small timeouts.
`timescale 1ns/1ps
`default_nettype none
`include "oswd_map.svh"
module tb_top;
    import oswd_pkg::*;
    typedef struct packed {logic [31:0] tmo; logic [3:0] ctrl; logic drop;} oswd_row_t;
    logic        sys_clk, reset, avs_read, avs_write, drop_link, link_up;
    logic [7:0]  avs_address, ao_norm, do_norm, co_norm, ao_out, do_out, co_out;
    logic [31:0] avs_writedata, avs_readdata, rd, rd2;
    logic        avs_waitrequest, wd_expired, app_notify, app_reset_req, unit_reset_req;
    logic        ops_allowed;
    int          err_count, check_count, cyc, n, na, nu;
    oswd_row_t   rows [5];

    oswd_top oswd_top_i (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .link_up(link_up), .ao_norm(ao_norm), .do_norm(do_norm), .co_norm(co_norm),
        .ao_out(ao_out), .do_out(do_out), .co_out(co_out), .wd_expired(wd_expired),
        .app_notify(app_notify), .app_reset_req(app_reset_req),
        .unit_reset_req(unit_reset_req), .ops_allowed(ops_allowed));
    oswd_host_model oswd_host_model_i (.drop_link(drop_link), .link_up(link_up),
        .ao_norm(ao_norm), .do_norm(do_norm), .co_norm(co_norm));

    // 25 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Hang guard, well above the longest expected run
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (err_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Request held until waitrequest is sampled low at a rising edge
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic do_reset(input int c);
        reset <= 1'b1;
        drop_link <= 1'b0;
        repeat (c) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Per-class forcing: all AO bits, low DO nibble, no CO bits
    task automatic setup(input logic [31:0] t);
        bus_wr(`OSWD_TIMEOUT_ADDR, t);
        bus_wr(`OSWD_AO_EN_ADDR, 32'h0000_00ff);
        bus_wr(`OSWD_DO_EN_ADDR, 32'h0000_000f);
        bus_wr(`OSWD_CO_EN_ADDR, 32'h0000_0000);
        bus_wr(`OSWD_AO_VAL_ADDR, 32'h0000_00a5);
        bus_wr(`OSWD_DO_VAL_ADDR, 32'h0000_003c);
        bus_wr(`OSWD_CO_VAL_ADDR, 32'h0000_0077);
    endtask
    // Counts cycles to expiry; a link drop is ordered five cycles in when asked
    task automatic wait_exp(input int lo, input int hi, input logic drop);
        n = 0;
        while (wd_expired !== 1'b1 && n < 1100) begin
            if (n == 5 && drop) drop_link <= 1'b1;
            @(posedge sys_clk);
            n++;
        end
        chk("expiry_cycles", 32'h1, {31'h0, (n >= lo && n <= hi)});
    endtask

    initial begin
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0000_0000;
        // Rows: timeout, control (action, link option, enable), link drop
        rows[0] = '{32'd20, 4'b0001, 1'b1};
        rows[1] = '{32'd10, 4'b0101, 1'b0};
        rows[2] = '{32'd5, 4'b1001, 1'b0};
        rows[3] = '{32'd30, 4'b1101, 1'b0};
        rows[4] = '{32'd1000, 4'b0011, 1'b1};
        do_reset(20);
        bus_rd(`OSWD_TIMEOUT_ADDR, rd);
        chk("timeout_reset", `OSWD_TIMEOUT_RST, rd);
        bus_rd(8'h3c, rd);
        chk("unmapped_read", 32'h0, rd);
        foreach (rows[i]) begin
            do_reset(2);
            setup(rows[i].tmo);
            chk("ao_before", 32'h11, {24'h0, ao_out});
            bus_wr(`OSWD_CTRL_ADDR, {28'h0, rows[i].ctrl});
            if (rows[i].drop && rows[i].ctrl[1]) wait_exp(5, 8, 1'b1);
            else wait_exp(rows[i].tmo, rows[i].tmo + 3, rows[i].drop);
            na = 0;
            nu = 0;
            repeat (12) begin
                @(posedge sys_clk);
                na += (app_reset_req === 1'b1);
                nu += (unit_reset_req === 1'b1);
            end
            chk("app_reset_pulse", (rows[i].ctrl[3:2] == 2'd1) ? 4 : 0, na);
            chk("unit_reset_pulse", (rows[i].ctrl[3:2] == 2'd2) ? 4 : 0, nu);
            if (rows[i].ctrl[3:2] == 2'd0 || rows[i].ctrl[3:2] == 2'd3)
                chk("notify", 32'h1, {31'h0, app_notify});
            chk("ao_forced", 32'ha5, {24'h0, ao_out});
            chk("do_forced", 32'hcc, {24'h0, do_out});
            chk("co_forced", 32'h5a, {24'h0, co_out});
            chk("ops_blocked", 32'h0, {31'h0, ops_allowed});
        end
        // Refreshes every 15 cycles hold off a 20-cycle timeout
        do_reset(2);
        setup(32'd20);
        bus_wr(`OSWD_CTRL_ADDR, 32'h0000_0001);
        repeat (6) begin
            repeat (12) @(posedge sys_clk);
            bus_wr(`OSWD_CMD_ADDR, `OSWD_CMD_REFRESH);
        end
        chk("no_expiry", 32'h0, {31'h0, wd_expired});
        wait_exp(20, 23, 1'b0);
        // Writes after expiry are refused, status still shows expiry
        bus_wr(`OSWD_TIMEOUT_ADDR, 32'h0000_0077);
        bus_rd(`OSWD_TIMEOUT_ADDR, rd);
        chk("timeout_frozen", 32'd20, rd);
        bus_rd(`OSWD_STATUS_ADDR, rd);
        chk("status_expired", 32'h1, {31'h0, rd[`OSWD_ST_EXPIRED]});
        // Unit reset brings outputs back to normal values
        do_reset(2);
        repeat (2) @(posedge sys_clk);
        chk("ao_after_rst", 32'h11, {24'h0, ao_out});
        chk("do_after_rst", 32'hc3, {24'h0, do_out});
        chk("expired_clear", 32'h0, {31'h0, wd_expired});
        // Full-width count runs down from a value near full scale
        setup(32'hffff_fff0);
        bus_wr(`OSWD_CTRL_ADDR, 32'h0000_0001);
        bus_rd(`OSWD_COUNT_ADDR, rd);
        bus_rd(`OSWD_COUNT_ADDR, rd2);
        chk("count_runs", 32'h1, {31'h0, (rd > rd2 && rd > 32'hffff_ff00)});
        end_sim();
    end
endmodule
`default_nettype wire
